//--- hdl/crr_pkg.sv
// package for the conversion result register bank
// assumes a 16-bit register port with word-indexed addresses
package crr_pkg;
  localparam int NumCh = 4;
  localparam int AddrW = 8;
  localparam int DataW = 16;
  localparam int ResW = 28;
  localparam int HighResW = 12;
  // register indices: channel n high at 2n, low at 2n+1
  localparam logic [7:0] ch0_result_high = 8'h00;
  localparam logic [7:0] ch0_result_low = 8'h01;
  localparam logic [7:0] ch1_result_high = 8'h02;
  localparam logic [7:0] ch1_result_low = 8'h03;
  localparam logic [7:0] ch2_result_high = 8'h04;
  localparam logic [7:0] ch2_result_low = 8'h05;
  localparam logic [7:0] ch3_result_high = 8'h06;
  localparam logic [7:0] ch3_result_low = 8'h07;
  localparam logic [7:0] LastResultIdx = 8'h07;
  // high register field positions
  localparam int UnderRangeBit = 15;
  localparam int OverRangeBit = 14;
  localparam int WatchdogBit = 13;
  localparam int AmplitudeBit = 12;
  localparam logic [15:0] ResultReset = 16'h0000;
  localparam logic [15:0] UnmappedValue = 16'h0000;

  typedef struct packed {
    logic underRange;
    logic overRange;
    logic watchdog;
    logic amplitude;
  } crr_err_t;

  typedef struct packed {
    logic valid;
    logic [27:0] data;
    crr_err_t err;
  } crr_conv_t;
endpackage

//--- hdl/crr_channel.sv
// one channel: latest result, sticky error flags, low-word snapshot
// assumes conversion results arrive as one-cycle pulses on clk
module crr_channel (
  input wire logic clk,                    // 40 MHz clock
  input wire logic resetn,                 // async reset, active low
  input crr_pkg::crr_conv_t conv,          // new conversion from the core
  input wire logic readHigh,               // high register read pulse
  output logic [15:0] highWord,            // high register image
  output logic [15:0] lowWord              // low register image
);
  logic [27:0] result_r;
  logic [15:0] lowHeld_r;
  crr_pkg::crr_err_t err_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= 28'h0000000;
    end else if (conv.valid) begin
      result_r <= conv.data;
    end
  end

  // set beats the read clear so a flag arriving during the read survives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_r <= '0;
    end else begin
      err_r.underRange <= (err_r.underRange & ~readHigh) | (conv.valid & conv.err.underRange); // RULE_01
      err_r.overRange <= (err_r.overRange & ~readHigh) | (conv.valid & conv.err.overRange); // RULE_02
      err_r.watchdog <= (err_r.watchdog & ~readHigh) | (conv.valid & conv.err.watchdog); // RULE_03
      err_r.amplitude <= (err_r.amplitude & ~readHigh) | (conv.valid & conv.err.amplitude); // RULE_04
    end
  end

  // low half frozen at the high read so a later conversion cannot tear the pair
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowHeld_r <= crr_pkg::ResultReset;
    end else if (readHigh) begin
      lowHeld_r <= result_r[15:0]; // RULE_10
    end
  end

  // flag positions come from the package so the layout is defined in one place
  always_comb begin
    highWord = {4'h0, result_r[27:16]}; // RULE_05
    highWord[crr_pkg::UnderRangeBit] = err_r.underRange; // RULE_01
    highWord[crr_pkg::OverRangeBit] = err_r.overRange; // RULE_02
    highWord[crr_pkg::WatchdogBit] = err_r.watchdog; // RULE_03
    highWord[crr_pkg::AmplitudeBit] = err_r.amplitude; // RULE_04
  end
  assign lowWord = lowHeld_r; // RULE_06
endmodule

//--- hdl/crr_result_regs.sv
// Function
// RULE_01: bit 15 under-range flag, cleared on read
// RULE_02: bit 14 over-range flag, cleared on read
// RULE_03: bit 13 watchdog flag, cleared on read
// RULE_04: bit 12 amplitude flag, cleared on read
// RULE_05: high bits 11:0 carry result 27:16
// RULE_06: low register carries result 15:0
// RULE_07: host reads high before low
// RULE_08: channel 2 low read after high
// RULE_09: channel 0 high at index 0x00
// RULE_10: high read snapshots matching low word
//
// read-only result register bank for four converter channels
// assumes the core pulses conv[n].valid with a finished conversion
module crr_result_regs #(
  parameter int NumCh = crr_pkg::NumCh
) (
  input wire logic clk,                              // 40 MHz clock
  input wire logic resetn,                           // async reset, active low
  input crr_pkg::crr_conv_t conv [NumCh],            // per-channel results
  input wire logic [7:0] regAddr,                    // register index
  input wire logic [15:0] regWdata,                  // write data, ignored
  input wire logic regWrite,                         // write strobe, ignored
  input wire logic regRead,                          // read strobe
  output logic [15:0] regRdata                       // read data, next cycle
);

  // what one register index selects
  typedef enum logic [1:0] {
    SelNone = 2'b00,
    SelHigh = 2'b01,
    SelLow = 2'b10
  } crr_sel_kind_t;

  // a decoded index: the kind of register and the channel it belongs to
  typedef struct packed {
    crr_sel_kind_t kind;
    logic [7:0] chan;
  } crr_sel_t;

  // offsets live in the package; a bank wider than this table has no indices
  localparam logic [7:0] HighIdx [crr_pkg::NumCh] = '{
    crr_pkg::ch0_result_high,
    crr_pkg::ch1_result_high,
    crr_pkg::ch2_result_high,
    crr_pkg::ch3_result_high
  };

  localparam logic [7:0] LowIdx [crr_pkg::NumCh] = '{
    crr_pkg::ch0_result_low,
    crr_pkg::ch1_result_low,
    crr_pkg::ch2_result_low,
    crr_pkg::ch3_result_low
  };

  logic [15:0] highWord [NumCh];
  logic [15:0] lowWord [NumCh];
  logic [NumCh-1:0] readHigh;
  crr_sel_t sel;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;

  // true when index a names the high register of channel ch
  function automatic logic isHighOf(input logic [7:0] a, input int ch);
    return a == HighIdx[ch];
  endfunction

  // true when index a names the low register of channel ch
  function automatic logic isLowOf(input logic [7:0] a, input int ch);
    return a == LowIdx[ch];
  endfunction

  // one decoder for the clear strobes and the read mux, so both agree
  function automatic crr_sel_t decodeSel(input logic [7:0] a);
    crr_sel_t s;
    s.kind = SelNone;
    s.chan = 8'h00;
    for (int i = 0; i < NumCh; i++) begin
      if (isHighOf(a, i)) begin
        s.kind = SelHigh;
        s.chan = 8'(i);
      end else if (isLowOf(a, i)) begin
        s.kind = SelLow;
        s.chan = 8'(i);
      end
    end
    return s;
  endfunction

  // true when a decoded index picks register kind k of channel ch
  function automatic logic picks(input crr_sel_t s, input crr_sel_kind_t k, input int ch);
    return s.kind == k && s.chan == 8'(ch);
  endfunction

  assign sel = decodeSel(regAddr);

  genvar g;
  generate
    for (g = 0; g < NumCh; g++) begin : gCh
      // only a read strobe clears; an index standing alone has no side effect
      assign readHigh[g] = regRead & picks(sel, SelHigh, g); // RULE_09

      crr_channel uChan (
        .clk(clk),
        .resetn(resetn),
        .conv(conv[g]),
        .readHigh(readHigh[g]),
        .highWord(highWord[g]),
        .lowWord(lowWord[g])
      );
    end
  endgenerate

  // reads of the high word before the low are the host's job; the
  // snapshot only guarantees coherence when that order is kept
  always_comb begin
    rdata_nxt = crr_pkg::UnmappedValue;
    for (int i = 0; i < NumCh; i++) begin
      if (picks(sel, SelHigh, i)) begin
        rdata_nxt = highWord[i];
      end else if (picks(sel, SelLow, i)) begin
        rdata_nxt = lowWord[i]; // RULE_07 RULE_08
      end
    end
  end

  // flags are cleared on the same edge the read data is captured
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= crr_pkg::ResultReset;
    end else if (regRead) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= crr_pkg::ResultReset;
    end
  end

  assign regRdata = rdata_r;
endmodule

//--- dv/crr_result_regs_assertions.sv
// port checker for the result register bank
// assumes one clock and the read answer one cycle after the strobe
module crr_result_regs_assertions #(
  parameter int NumCh = 4
) (
  input wire logic clk, // bank clock
  input wire logic resetn, // async reset, active low
  input crr_pkg::crr_conv_t conv [NumCh], // conversions from the core
  input wire logic [7:0] regAddr, // register index
  input wire logic regRead, // read strobe
  input logic [15:0] regRdata // read data, cycle after the strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rh1;
    regRead && regAddr == 8'h02 && !conv[1].valid;
  endsequence
  a_flags_clear: assert property (rh1 ##1 rh1 |=> regRdata[15:12] == 4'h0)
    else $error("flags survived a read");
  a_flags_set: assert property (conv[1].valid ##1 rh1 |=>
    (regRdata[15:12] & $past(conv[1].err, 2)) == $past(conv[1].err, 2)) else $error("flag lost");
  a_high_data: assert property (conv[1].valid ##1 rh1 |=>
    regRdata[11:0] == $past(conv[1].data[27:16], 2)) else $error("high data wrong");
  a_ch0_high: assert property (conv[0].valid ##1 regRead && regAddr == 8'h00 && !conv[0].valid
    |=> regRdata[11:0] == $past(conv[0].data[27:16], 2)) else $error("ch0 high wrong");
  a_ch3_high: assert property (conv[3].valid ##1 regRead && regAddr == 8'h06 && !conv[3].valid
    |=> regRdata[11:0] == $past(conv[3].data[27:16], 2)) else $error("ch3 high wrong");
  a_low_snap: assert property (conv[1].valid ##1 rh1 ##1 regRead && regAddr == 8'h03
    |=> regRdata == $past(conv[1].data[15:0], 3)) else $error("low word wrong");
  a_set_wins: assert property (conv[1].valid && regRead && regAddr == 8'h02 ##1 rh1 |=>
    regRdata[15:12] == $past(conv[1].err, 2)) else $error("flag lost to a read clear");
  a_unmapped_read: assert property ($past(regRead) && $past(regAddr) > 8'h07 |->
    regRdata == 16'h0000) else $error("unmapped read not zero");
  a_idle_zero: assert property (!$past(regRead) |-> regRdata == 16'h0000) else $error("data w/o read");
endmodule
bind crr_result_regs crr_result_regs_assertions #(.NumCh(NumCh)) i_crr_chk (.clk(clk),
  .resetn(resetn), .conv(conv), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata));

//--- dv/crr_host_model.sv
// host side of the register port: strobes held until the next go, no waiting
// assumes the caller enters go right after a rising clock edge
module crr_host_model (
  output logic [7:0] regAddr, // register index
  output logic [15:0] regWdata, // write data
  output logic regWrite, // write strobe
  output logic regRead // read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {regAddr, regWdata, regWrite, regRead} = '0;
  task automatic go(input logic rd, input logic wr, input int a, input int d);
    regRead <= rd;
    regWrite <= wr;
    regAddr <= 8'(a);
    regWdata <= 16'(d);
  endtask
endmodule

//--- dv/tb.sv
// random bench: conversions, high/low read pairs, writes, unmapped reads
// assumes the answer stands in the cycle after each read strobe
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, regWrite, regRead;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata;
  crr_pkg::crr_conv_t conv [4], cv;
  int n_fail = 0, n_tests = 0, dat [4], err [4], snap [4];
  int ex0 = 0, ex1 = 0, lowCh = -1, c, k, e, rdHi;
  always #12.5 clk = ~clk;
  crr_result_regs i_crr_result_regs (.clk(clk), .resetn(resetn), .conv(conv), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  crr_host_model i_crr_host_model (.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead));
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #60000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(41523));
    foreach (conv[i]) conv[i] = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (1500) begin
      @(posedge clk);
      ex0 = 0;
      cv = '0;
      k = $urandom_range(3);
      c = $urandom_range(3);
      if (lowCh >= 0 && k > 0) begin
        ex0 = snap[lowCh];
        i_crr_host_model.go(1, 0, 2 * lowCh + 1, 0);
        lowCh = -1;
      end else if (k == 0) begin
        rdHi = $urandom_range(1);
        if (rdHi == 1) begin
          // a high read beside a conversion returns the old word; the new flags win
          ex0 = (err[c] << 12) | (dat[c] >> 16);
          snap[c] = dat[c] & 32'hffff;
          err[c] = 0;
          lowCh = c;
          i_crr_host_model.go(1, 0, 2 * c, 0);
        end else begin
          // writes land beside conversions; every register must ignore them
          i_crr_host_model.go(0, 1, $urandom_range(15), $urandom);
        end
        dat[c] = $urandom & 32'h0fffffff;
        e = $urandom_range(15);
        err[c] |= e;
        cv = {1'b1, dat[c][27:0], e[3:0]};
      end else if (k == 1) begin
        i_crr_host_model.go(1, 0, $urandom_range(255, 8), 0);
      end else begin
        ex0 = (err[c] << 12) | (dat[c] >> 16);
        err[c] = 0;
        snap[c] = dat[c] & 32'hffff;
        i_crr_host_model.go(1, 0, 2 * c, 0);
        if ($urandom_range(1) == 1) lowCh = c;
      end
      // one assignment per channel: only the chosen one carries a conversion
      foreach (conv[i]) conv[i] <= (i == c) ? cv : crr_pkg::crr_conv_t'(0);
      // the answer to the previous strobe is settled by the falling edge
      @(negedge clk);
      n_tests++;
      if (regRdata !== 16'(ex1)) begin
        n_fail++;
        $display("ERROR regRdata expected %h seen %h", 16'(ex1), regRdata);
      end
      ex1 = ex0;
    end
    tally_and_finish();
  end
endmodule
